// >>> design/nfc_host.sv
// Host-side sequencer for a large-page NAND flash: issues commands, addresses and data bytes.
// Assumes the flash pins are synchronous to clk and the bench resolves the shared bus wire.
//
// Contract
// - Address is 28 bits in four cycles: two column then two row bytes.
// - Host drives upper four bits of second address cycle low.
// - Page read is 00h, four address cycles, 30h, then busy.
// - Page program is 80h, four address cycles, data, then 10h.
// - Cache program ends with 15h instead of 10h.
// - Copy-back reads with 00h then 35h, programs with 85h, address, 10h.
// - Block erase is 60h, two row address cycles, D0h.
// - 85h with column moves input point; 05h, column, E0h move output point.
// - Read ID is 90h then one address cycle; reset FFh and status 70h are one cycle; only last two when busy.
// - Host never issues a command code outside the defined set.
// - Host writes every byte by pulsing input strobe low with chip enable low.
`timescale 1ns/1ps
`default_nettype none
module nfc_host
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfc_req_s req,
  input wire logic write_lock,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic flash_busy,
  output nfc_pins_s pins,
  input wire logic [7:0] bus_in,
  input wire logic busy_flag_n
);

  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_DATA_W, S_READ_B, S_CMD2, S_WAIT_BUSY, S_FINISH
  } nfc_state_e;

  typedef struct packed {
    nfc_state_e state;
    nfc_req_s r;
    logic [2:0] aidx;
    logic [11:0] left;
    logic go;
    logic [7:0] rdat;
    logic rval;
    logic done;
    logic wtake;
    logic rdy;
    logic fbusy;
    nfc_pins_s p;
  } nfc_host_s;

  nfc_host_s st;
  nfc_host_s next_st;
  logic stb_low;
  logic stb_sample;
  logic stb_done;
  logic [7:0] first_cmd;
  logic [7:0] second_cmd;
  logic has_second;
  logic [2:0] addr_first;
  logic [2:0] addr_last;
  logic [7:0] addr_byte;
  logic writes_data;
  logic reads_data;
  logic waits_busy;

  nfc_strobe u_strobe (
    .clk(clk),
    .nrst(nrst),
    .start(st.go),
    .strobe_low(stb_low),
    .sample(stb_sample),
    .done(stb_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-operation decode: only codes of the defined set can ever be produced
  always_comb begin
    first_cmd = CMD_READ_SETUP;
    second_cmd = CMD_READ_CONFIRM;
    has_second = 1'b1;
    addr_first = 3'h0;
    addr_last = 3'h4;
    writes_data = 1'b0;
    reads_data = 1'b0;
    waits_busy = 1'b1;
    case (st.r.op)
      NFC_OP_READ: reads_data = 1'b1;
      NFC_OP_COPY_READ: second_cmd = CMD_COPY_READ_CONFIRM;
      NFC_OP_READ_ID, NFC_OP_STATUS: begin
        first_cmd = (st.r.op == NFC_OP_READ_ID) ? CMD_READ_ID : CMD_READ_STATUS;
        has_second = 1'b0;
        addr_last = (st.r.op == NFC_OP_READ_ID) ? 3'h1 : 3'h0;
        reads_data = 1'b1;
        waits_busy = 1'b0;
      end
      NFC_OP_RESET: begin
        first_cmd = CMD_RESET;
        has_second = 1'b0;
        addr_last = 3'h0;
      end
      NFC_OP_PROGRAM, NFC_OP_CACHE_PROGRAM, NFC_OP_COPY_PROGRAM: begin
        first_cmd = (st.r.op == NFC_OP_COPY_PROGRAM) ? CMD_COPY_PROG_SETUP : CMD_PROG_SETUP;
        second_cmd = (st.r.op == NFC_OP_CACHE_PROGRAM) ? CMD_CACHE_CONFIRM : CMD_PROG_CONFIRM;
        writes_data = 1'b1;
      end
      NFC_OP_ERASE: begin
        first_cmd = CMD_ERASE_SETUP;
        second_cmd = CMD_ERASE_CONFIRM;
        addr_first = 3'h2;
      end
      NFC_OP_RAND_IN: begin
        first_cmd = CMD_COPY_PROG_SETUP;
        has_second = 1'b0;
        addr_last = 3'h2;
        writes_data = 1'b1;
        waits_busy = 1'b0;
      end
      NFC_OP_RAND_OUT: begin
        first_cmd = CMD_RAND_OUT_SETUP;
        second_cmd = CMD_RAND_OUT_CONFIRM;
        addr_last = 3'h2;
        reads_data = 1'b1;
        waits_busy = 1'b0;
      end
      default: begin
        first_cmd = CMD_READ_STATUS;
        has_second = 1'b0;
        addr_last = 3'h0;
        waits_busy = 1'b0;
      end
    endcase
    // A read of zero bytes skips its data phase; it ends after its commands, address cycles and any busy wait
    if (st.r.count == 12'h0) reads_data = 1'b0;
  end

  // Address cycle layout; second cycle upper nibble forced low
  always_comb begin
    case (st.aidx)
      3'h0: addr_byte = st.r.addr[7:0];
      3'h1: addr_byte = {4'h0, st.r.addr[11:8]};
      3'h2: addr_byte = st.r.addr[19:12];
      3'h3: addr_byte = st.r.addr[27:20];
      default: addr_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_st = st;
    next_st.go = 1'b0;
    next_st.rval = 1'b0;
    next_st.done = 1'b0;
    next_st.wtake = 1'b0;
    next_st.p.program_lock_n = write_lock ? 1'b0 : 1'b1;
    next_st.p.input_strobe_n = 1'b1;
    next_st.p.output_strobe_n = 1'b1;
    case (st.state)
      S_IDLE: begin
        next_st.p.chip_enable_n = 1'b1;
        next_st.p.bus_oe = 1'b0;
        if (req_valid) begin
          next_st.r = req;
          next_st.state = S_CMD1;
          next_st.p.chip_enable_n = 1'b0;
          next_st.go = 1'b1;
        end
      end
      S_CMD1, S_CMD2: begin
        next_st.p.command_latch_select = 1'b1;
        next_st.p.bus_oe = 1'b1;
        next_st.p.bus_out = (st.state == S_CMD1) ? first_cmd : second_cmd;
        next_st.p.input_strobe_n = !stb_low;
        if (stb_done && !st.go) begin
          next_st.p.command_latch_select = 1'b0;
          next_st.aidx = addr_first;
          next_st.left = st.r.count;
          next_st.go = 1'b1;
          if (st.state == S_CMD1 && addr_last != 3'h0) begin
            next_st.state = S_ADDR;
          end else begin
            next_st.state = waits_busy ? S_WAIT_BUSY : (reads_data ? S_READ_B : S_FINISH);
            next_st.go = !waits_busy && reads_data;
            next_st.p.bus_oe = waits_busy || !reads_data;
          end
        end
      end
      S_ADDR: begin
        next_st.p.address_capture_select = 1'b1;
        next_st.p.bus_out = addr_byte;
        next_st.p.input_strobe_n = !stb_low;
        if (stb_done && !st.go) begin
          next_st.aidx = st.aidx + 3'h1;
          next_st.go = 1'b1;
          if (st.aidx + 3'h1 == addr_last) begin
            next_st.p.address_capture_select = 1'b0;
            if (writes_data && st.r.count != 12'h0) begin
              next_st.state = S_DATA_W;
              next_st.go = 1'b0;
            end else if (has_second) begin
              next_st.state = S_CMD2;
            end else if (reads_data) begin
              next_st.state = S_READ_B;
              next_st.p.bus_oe = 1'b0;
            end else begin
              next_st.state = S_FINISH;
              next_st.go = 1'b0;
            end
          end
        end
      end
      S_DATA_W: begin
        next_st.p.input_strobe_n = !stb_low;
        if (stb_done && !st.go) begin
          if (st.left == 12'h0) begin
            next_st.state = has_second ? S_CMD2 : S_FINISH;
            next_st.go = has_second;
          end else if (wr_valid) begin
            next_st.p.bus_out = wr_data;
            next_st.wtake = 1'b1;
            next_st.left = st.left - 12'h1;
            next_st.go = 1'b1;
          end
        end
      end
      S_READ_B: begin
        next_st.p.bus_oe = 1'b0;
        next_st.p.output_strobe_n = !stb_low;
        if (stb_sample) begin
          next_st.rdat = bus_in;
          next_st.rval = 1'b1;
          next_st.left = st.left - 12'h1;
        end
        if (stb_done && !st.go) begin
          if (st.left == 12'h0) begin
            next_st.state = S_FINISH;
          end else begin
            next_st.go = 1'b1;
          end
        end
      end
      S_WAIT_BUSY: begin
        // Chip enable stays low; flash ignores it anyway while busy
        if (stb_done && !st.go && busy_flag_n) begin
          next_st.state = reads_data ? S_READ_B : S_FINISH;
          next_st.go = reads_data;
          next_st.p.bus_oe = !reads_data;
        end
      end
      S_FINISH: begin
        next_st.p.chip_enable_n = 1'b1;
        next_st.p.bus_oe = 1'b0;
        next_st.done = 1'b1;
        next_st.state = S_IDLE;
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
    next_st.rdy = (next_st.state == S_IDLE);
    next_st.fbusy = (next_st.state == S_WAIT_BUSY);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '{state: S_IDLE, r: '0, aidx: 3'h0, left: 12'h0, go: 1'b0, rdat: 8'h00,
              rval: 1'b0, done: 1'b0, wtake: 1'b0, rdy: 1'b1, fbusy: 1'b0,
              p: '{chip_enable_n: 1'b1, command_latch_select: 1'b0,
                   address_capture_select: 1'b0, input_strobe_n: 1'b1,
                   output_strobe_n: 1'b1, program_lock_n: 1'b0, bus_out: 8'h00,
                   bus_oe: 1'b0}};
    end else begin
      st <= next_st;
    end
  end

  assign pins = st.p;
  assign rd_data = st.rdat;
  assign rd_valid = st.rval;
  assign op_done = st.done;
  assign wr_take = st.wtake;
  assign req_ready = st.rdy;
  assign flash_busy = st.fbusy;

endmodule // nfc_host
`default_nettype wire

// >>> design/nfc_pkg.sv
// Package for the NAND flash host sequencer: command codes, address layout, timing counts.
// Assumes a 20 MHz clock and a controller that owns every strobe of the flash.
package nfc_pkg;

  localparam int CLK_MHZ = 20;
  // Strobe low and high phase, in ns, rounded up to whole cycles
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC < 1 ? 1 : STROBE_CYC);

  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COPY_READ_CONFIRM = 8'h35;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_CACHE_CONFIRM = 8'h15;
  localparam logic [7:0] CMD_COPY_PROG_SETUP = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_RAND_OUT_SETUP = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CONFIRM = 8'he0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 16;
  localparam int ADDR_BITS = 28;
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam logic [11:0] SPARE_START = 12'h800;

  // Host operations
  typedef enum logic [3:0] {
    NFC_OP_READ, NFC_OP_COPY_READ, NFC_OP_READ_ID, NFC_OP_RESET,
    NFC_OP_PROGRAM, NFC_OP_CACHE_PROGRAM, NFC_OP_COPY_PROGRAM, NFC_OP_ERASE,
    NFC_OP_RAND_IN, NFC_OP_RAND_OUT, NFC_OP_STATUS
  } nfc_op_e;

  typedef struct packed {
    nfc_op_e op;
    logic [ADDR_BITS-1:0] addr;
    logic [11:0] count;
  } nfc_req_s;

  // Flash pin bundle driven by the host
  typedef struct packed {
    logic chip_enable_n;
    logic command_latch_select;
    logic address_capture_select;
    logic input_strobe_n;
    logic output_strobe_n;
    logic program_lock_n;
    logic [7:0] bus_out;
    logic bus_oe;
  } nfc_pins_s;

endpackage : nfc_pkg

// >>> design/nfc_strobe.sv
// Strobe timer: produces a low phase then a high phase of a write or read strobe.
// Assumes start is only pulsed while done is high.
`timescale 1ns/1ps
`default_nettype none
module nfc_strobe
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  output logic strobe_low,
  output logic sample,
  output logic done
);

  typedef struct packed {
    logic low;
    logic busy;
    logic smp;
    logic [3:0] cnt;
  } nfc_strobe_s;

  nfc_strobe_s st;
  nfc_strobe_s next_st;

  always_comb begin
    next_st = st;
    next_st.smp = 1'b0;
    if (start && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.low = 1'b1;
      next_st.cnt = STROBE_CNT;
    end else if (st.busy) begin
      if (st.cnt > 4'h1) begin
        next_st.cnt = st.cnt - 4'h1;
      end else if (st.low) begin
        // Data is taken at the end of the low phase, just before the rising edge
        next_st.low = 1'b0;
        next_st.smp = 1'b1;
        next_st.cnt = STROBE_CNT;
      end else begin
        next_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign strobe_low = st.low;
  assign sample = st.smp;
  assign done = !st.busy;

endmodule // nfc_strobe
`default_nettype wire

// >>> dv/nfc_flash_model.sv
// Behavioural flash device on the far side of the host pins.
// Assumes pins change only at clk edges; bus is resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int BUSY_CYC = 12,
  parameter logic [7:0] ID_BYTE = 8'h5a
)
(
  input wire logic clk,
  input wire nfc_pins_s pins,
  output logic [7:0] dq,
  output logic busy_flag_n
);
  logic [7:0] mem [logic [27:0]];
  logic [7:0] pend [logic [27:0]];
  logic [27:0] kq [$];
  nfc_pins_s cap;
  logic [7:0] cmd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [11:0] col = 12'h000;
  logic [15:0] row = 16'h0000;
  logic [15:0] src = 16'h0000;
  logic cpy = 1'b0;
  logic we_d = 1'b1;
  logic re_d = 1'b1;
  int na = 0;
  int busy = 0;
  assign busy_flag_n = (busy == 0);
  // Status layout is arbitrary here; released bus shows the inverse of the last byte
  always @* begin
    if (!pins.chip_enable_n && !pins.output_strobe_n) begin
      if (cmd == CMD_READ_STATUS) dq = {pins.program_lock_n, busy == 0, 6'h00};
      else if (cmd == CMD_READ_ID) dq = ID_BYTE;
      else dq = mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
    end else dq = ~last;
  end
  always @(posedge clk) begin
    we_d <= pins.input_strobe_n;
    re_d <= pins.output_strobe_n;
    if (busy > 0) busy <= busy - 1;
    if (!pins.chip_enable_n && !pins.output_strobe_n) last <= dq;
    if (!re_d && pins.output_strobe_n && !pins.chip_enable_n) col <= col + 12'h001;
    if (!pins.input_strobe_n) cap <= pins;
    if (!we_d && pins.input_strobe_n && !cap.chip_enable_n) begin
      if (cap.command_latch_select) begin
        if (busy == 0 || cap.bus_out inside {CMD_RESET, CMD_READ_STATUS}) begin
          cmd <= cap.bus_out;
          na <= (cap.bus_out == CMD_ERASE_SETUP) ? 2 : 0;
          case (cap.bus_out)
            CMD_RESET: busy <= 0;
            CMD_PROG_SETUP: begin pend.delete(); cpy <= 1'b0; end
            CMD_READ_CONFIRM: busy <= BUSY_CYC;
            CMD_COPY_READ_CONFIRM: begin src <= row; cpy <= 1'b1; busy <= BUSY_CYC; end
            CMD_PROG_CONFIRM, CMD_CACHE_CONFIRM: begin
              if (cap.program_lock_n) begin
                if (cpy) foreach (mem[k]) if (k[27:12] == src) pend[{row, k[11:0]}] = mem[k];
                foreach (pend[k]) mem[k] = pend[k];
                busy <= BUSY_CYC;
              end
              // A refused page must not leak into a later copy-back
              pend.delete();
            end
            CMD_ERASE_CONFIRM: if (cap.program_lock_n) begin
              kq.delete();
              foreach (mem[k]) if (k[27:18] == row[15:6]) kq.push_back(k);
              foreach (kq[i]) mem.delete(kq[i]);
              busy <= BUSY_CYC;
            end
            default: ;
          endcase
        end
      end else if (cap.address_capture_select) begin
        if (na < 4) begin
          case (na)
            0: col[7:0] <= cap.bus_out;
            1: col[11:8] <= cap.bus_out[3:0];
            2: row[7:0] <= cap.bus_out;
            default: row[15:8] <= cap.bus_out;
          endcase
          na <= na + 1;
        end
      end else begin
        pend[{row, col}] = cap.bus_out;
        col <= col + 12'h001;
      end
    end
  end
endmodule // nfc_flash_model
`default_nettype wire

// >>> dv/nfc_host_chk.sv
// Pin protocol checker for the NAND host sequencer.
// Assumes it sees only the nfc_host ports through bind.
`timescale 1ns/1ps
`default_nettype none
module nfc_host_chk
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire nfc_req_s req,
  input wire logic write_lock,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_take,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic op_done,
  input wire logic flash_busy,
  input wire nfc_pins_s pins,
  input wire logic [7:0] bus_in,
  input wire logic busy_flag_n
);
  logic [2:0] acnt;
  logic [7:0] lcmd;
  // Address cycles since the last command byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acnt <= 3'h0;
      lcmd <= 8'h00;
    end else if ($fell(pins.input_strobe_n) && pins.command_latch_select) begin
      acnt <= 3'h0;
      lcmd <= pins.bus_out;
    end else if ($fell(pins.input_strobe_n) && pins.address_capture_select) begin
      acnt <= acnt + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_lock_follow: assert property ($past(nrst) |-> pins.program_lock_n == !$past(write_lock))
    else $error("program lock not following write_lock");
  a_strobe_sel: assert property (!pins.input_strobe_n |-> !pins.chip_enable_n)
    else $error("input strobe low while deselected");
  a_strobe_pulse: assert property ($fell(pins.input_strobe_n) |=> pins.input_strobe_n)
    else $error("input strobe low phase too long");
  a_bus_release: assert property (!pins.output_strobe_n |-> !pins.bus_oe)
    else $error("host drives bus during read strobe");
  a_cmd_legal: assert property (!pins.input_strobe_n && pins.command_latch_select |->
    pins.bus_out inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hff, 8'h80, 8'h10, 8'h15,
    8'h85, 8'h60, 8'hd0, 8'h05, 8'he0, 8'h70})
    else $error("undefined command code");
  a_addr_nibble: assert property ($fell(pins.input_strobe_n) && pins.address_capture_select &&
    acnt == 3'h1 && lcmd != CMD_ERASE_SETUP |-> pins.bus_out[7:4] == 4'h0)
    else $error("second address byte upper nibble not low");
  a_rd_sample: assert property (rd_valid |-> rd_data == $past(bus_in))
    else $error("read byte differs from bus");
  a_ready_drop: assert property (req_valid && req_ready |=> !req_ready ##1 !req_ready)
    else $error("ready after request taken");
  a_take_data: assert property (wr_take |-> $past(wr_valid) && pins.bus_out == $past(wr_data))
    else $error("data byte taken without valid or not placed on bus");
endmodule // nfc_host_chk
bind nfc_host nfc_host_chk nfc_host_chk_i (.clk, .nrst, .req_valid, .req_ready, .req,
  .write_lock, .wr_data, .wr_valid, .wr_take, .rd_data, .rd_valid, .op_done, .flash_busy,
  .pins, .bus_in, .busy_flag_n);
`default_nettype wire

// >>> dv/nfc_host_tb.sv
// Self-checking bench: host sequencer against a behavioural flash.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module nfc_host_tb;
  import nfc_pkg::*;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary identity byte
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, write_lock = 1'b0, wr_valid = 1'b1;
  logic req_ready, wr_take, rd_valid, op_done, flash_busy, busy_flag_n, saw_busy;
  logic [7:0] wr_data = 8'h00, rd_data, bus_in, fl_dq;
  nfc_req_s req = '0;
  nfc_pins_s pins;
  logic [7:0] wbuf [0:7];
  logic [7:0] rq [$];
  int wp = 0, vcnt = 0, err_count = 0, n_tests = 0;
  always #25 clk = ~clk;
  assign bus_in = pins.bus_oe ? pins.bus_out : fl_dq;
  nfc_host nfc_host_i (.clk, .nrst, .req_valid, .req_ready, .req, .write_lock, .wr_data,
    .wr_valid, .wr_take, .rd_data, .rd_valid, .op_done, .flash_busy, .pins, .bus_in,
    .busy_flag_n);
  nfc_flash_model #(.BUSY_CYC(12), .ID_BYTE(ID)) nfc_flash_model_i (.clk, .pins, .dq(fl_dq),
    .busy_flag_n);
  // Data source stalls one cycle in three so the host must wait for valid
  always @(posedge clk) begin
    vcnt <= (vcnt + 1) % 3;
    wr_valid <= (vcnt != 0);
  end
  always @(posedge clk) if (wr_take === 1'b1) begin
    wp <= wp + 1;
    wr_data <= wbuf[(wp + 1) % 8];
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run_op(input nfc_op_e op, input logic [15:0] row, input logic [11:0] col,
      input logic [11:0] cnt);
    int i;
    rq.delete();
    saw_busy = 1'b0;
    @(posedge clk);
    wp <= 0;
    wr_data <= wbuf[0];
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: {row, col}, count: cnt};
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (flash_busy === 1'b1) saw_busy = 1'b1;
      if (op_done === 1'b1) break;
    end
    chk("op_done", {31'h0, op_done}, 32'h1);
  endtask
  task automatic check_rd(input logic [7:0] b, input int n, input logic [7:0] step);
    chk("rd_count", rq.size(), n);
    for (int i = 0; i < n && i < rq.size(); i++) chk("rd_data", rq[i], b + step * i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_prog_read;
    for (int i = 0; i < 8; i++) wbuf[i] = 8'ha0 + i;
    run_op(NFC_OP_PROGRAM, 16'h0005, 12'h7fe, 12'h004);
    chk("prog_busy", {31'h0, saw_busy}, 32'h1);
    run_op(NFC_OP_READ, 16'h0005, 12'h7fe, 12'h004);
    check_rd(8'ha0, 4, 8'h01);
  endtask
  task automatic t_lock;
    write_lock <= 1'b1;
    wbuf[0] = 8'hb0;
    run_op(NFC_OP_PROGRAM, 16'h0006, 12'h000, 12'h001);
    write_lock <= 1'b0;
    run_op(NFC_OP_READ, 16'h0006, 12'h000, 12'h001);
    check_rd(8'hff, 1, 8'h00);
  endtask
  task automatic t_copy_rand;
    run_op(NFC_OP_COPY_READ, 16'h0005, 12'h7fe, 12'h000);
    run_op(NFC_OP_COPY_PROGRAM, 16'h0049, 12'h7fe, 12'h000);
    run_op(NFC_OP_READ, 16'h0049, 12'h7fe, 12'h004);
    check_rd(8'ha0, 4, 8'h01);
    run_op(NFC_OP_READ, 16'h0005, 12'h000, 12'h000);
    run_op(NFC_OP_RAND_OUT, 16'h0005, 12'h7ff, 12'h002);
    check_rd(8'ha1, 2, 8'h01);
  endtask
  task automatic t_erase;
    run_op(NFC_OP_ERASE, 16'h0009, 12'h000, 12'h000);
    chk("erase_busy", {31'h0, saw_busy}, 32'h1);
    run_op(NFC_OP_READ, 16'h0005, 12'h7fe, 12'h001);
    check_rd(8'hff, 1, 8'h00);
    run_op(NFC_OP_READ, 16'h0049, 12'h7fe, 12'h001);
    check_rd(8'ha0, 1, 8'h00);
  endtask
  task automatic t_singles;
    nfc_op_e ops [5] = '{NFC_OP_STATUS, NFC_OP_READ_ID, NFC_OP_RESET, NFC_OP_CACHE_PROGRAM,
      NFC_OP_RAND_IN};
    int nrd [5] = '{1, 1, 0, 0, 0};
    for (int i = 0; i < 5; i++) begin
      run_op(ops[i], 16'h0080, 12'h000, 12'h001);
      chk("rd_count", rq.size(), nrd[i]);
    end
    run_op(NFC_OP_READ, 16'h0080, 12'h000, 12'h001);
    check_rd(8'hb0, 1, 8'h00);
    run_op(NFC_OP_STATUS, 16'h0000, 12'h000, 12'h001);
    check_rd(8'hc0, 1, 8'h00);
    run_op(NFC_OP_READ_ID, 16'h0000, 12'h000, 12'h001);
    check_rd(ID, 1, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    err_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_prog_read();
    t_lock();
    t_copy_rand();
    t_erase();
    t_singles();
    summarize();
  end
endmodule // nfc_host_tb
`default_nettype wire
